//--- rtl/setpoint_summer_defines.svh
// Register offsets, field positions, reset values and limits of the setpoint summer.
`ifndef SETPOINT_SUMMER_DEFINES_SVH
`define SETPOINT_SUMMER_DEFINES_SVH

`define SPS_OFS_INPUT0     12'h000
`define SPS_OFS_INPUT1     12'h004
`define SPS_OFS_INPUT2     12'h008
`define SPS_OFS_RATIO0     12'h00C
`define SPS_OFS_RATIO1     12'h010
`define SPS_OFS_DIVIDER0   12'h014
`define SPS_OFS_DIVIDER1   12'h018
`define SPS_OFS_CTRL       12'h01C
`define SPS_OFS_LIMIT      12'h020
`define SPS_OFS_OUT0       12'h024
`define SPS_OFS_OUT1       12'h028
`define SPS_OFS_SUM        12'h02C

`define SPS_CTRL_SIGN0     0
`define SPS_CTRL_SIGN1     1

`define SPS_INPUT_MAX      17'sh0_7530
`define SPS_COEF_MAX       17'sh0_7530
`define SPS_LIMIT_MAX      17'sh0_4E20

`define SPS_RST_INPUT      16'h0000
`define SPS_RST_COEF       16'h2710
`define SPS_RST_LIMIT      16'h2710
`define SPS_RST_SIGN       1'b1

`define SPS_HTRANS_NONSEQ  2'b10
`define SPS_HSIZE_WORD     3'b010

`endif

//--- rtl/setpoint_summer_pkg.sv
// Types shared by the setpoint summer.
package setpoint_summer_pkg;

  typedef logic signed [15:0] pct_t;

  typedef enum logic [1:0]
  {
    ph_idle,
    ph_write,
    ph_read_wait,
    ph_read_done
  } phase_e;

endpackage

//--- rtl/setpoint_summer.sv
// Setpoint summer: two scaled channels, one direct input, clamped total, AHB-Lite registers.
`include "setpoint_summer_defines.svh"

module setpoint_summer
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  output logic      [15:0] summed_setpoint_out,
  output logic      [15:0] channel_zero_scaled_out,
  output logic      [15:0] channel_one_scaled_out
);

  // Saturates a wide signed value to +/-lim; lim is never negative.
  function automatic setpoint_summer_pkg::pct_t sat
  (
    input logic signed [31:0] v,
    input logic signed [16:0] lim
  );
    logic signed [31:0] l;
    l = 32'(lim);
    if (v > l)
    begin
      sat = 16'(l);
    end
    else if (v < -l)
    begin
      sat = 16'(-l);
    end
    else
    begin
      sat = 16'(v);
    end
  endfunction

  // Scales one channel; a zero divider forces zero instead of dividing.
  function automatic setpoint_summer_pkg::pct_t scale
  (
    input setpoint_summer_pkg::pct_t in,
    input setpoint_summer_pkg::pct_t ratio,
    input setpoint_summer_pkg::pct_t div,
    input logic                      positive,
    input setpoint_summer_pkg::pct_t lim
  );
    logic signed [31:0] prod;
    logic signed [31:0] quot;
    prod = 32'(in) * 32'(ratio);
    quot = 32'sh0000_0000;
    if (div != 16'sh0000)
    begin
      quot = prod / 32'(div);
    end
    if (!positive)
    begin
      quot = -quot;
    end
    scale = sat(quot, 17'(lim));
  endfunction

  setpoint_summer_pkg::pct_t in0_q;
  setpoint_summer_pkg::pct_t in1_q;
  setpoint_summer_pkg::pct_t in2_q;
  setpoint_summer_pkg::pct_t ratio0_q;
  setpoint_summer_pkg::pct_t ratio1_q;
  setpoint_summer_pkg::pct_t div0_q;
  setpoint_summer_pkg::pct_t div1_q;
  setpoint_summer_pkg::pct_t limit_q;
  logic                      sign0_q;
  logic                      sign1_q;

  setpoint_summer_pkg::pct_t ch0_d;
  setpoint_summer_pkg::pct_t ch1_d;
  setpoint_summer_pkg::pct_t sum_d;
  setpoint_summer_pkg::pct_t ch0_q;
  setpoint_summer_pkg::pct_t ch1_q;
  setpoint_summer_pkg::pct_t sum_q;

  setpoint_summer_pkg::phase_e phase_q;
  logic [11:0]                 addr_q;
  logic                        accept;
  logic                        wr_ok;
  setpoint_summer_pkg::pct_t   wdata_in;
  setpoint_summer_pkg::pct_t   wdata_coef;
  setpoint_summer_pkg::pct_t   wdata_lim;
  logic [31:0]                 rdata_d;
  logic [31:0]                 rdata_q;

  // The master may only start while the bus is ready, and the bus is never ready while frozen.
  assign hreadyout = ce && (phase_q != setpoint_summer_pkg::ph_read_wait);
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;
  assign accept    = hsel && (htrans == `SPS_HTRANS_NONSEQ) && hreadyout;
  assign wr_ok     = ce && (phase_q == setpoint_summer_pkg::ph_write);

  // Out-of-range writes are saturated into range rather than refused.
  assign wdata_in   = sat(hwdata, `SPS_INPUT_MAX);
  assign wdata_coef = sat(hwdata, `SPS_COEF_MAX);
  assign wdata_lim  = hwdata[31] ? 16'sh0000 : sat(hwdata, `SPS_LIMIT_MAX);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      phase_q <= setpoint_summer_pkg::ph_idle;
      addr_q  <= 12'h000;
    end
    else if (ce)
    begin
      case (phase_q)
        setpoint_summer_pkg::ph_read_wait:
        begin
          phase_q <= setpoint_summer_pkg::ph_read_done;
        end
        default:
        begin
          if (accept && hwrite)
          begin
            // Sub-word writes are not mapped; they complete but store nothing.
            phase_q <= (hsize == `SPS_HSIZE_WORD) ? setpoint_summer_pkg::ph_write
                                                  : setpoint_summer_pkg::ph_idle;
            addr_q  <= haddr;
          end
          else if (accept)
          begin
            phase_q <= setpoint_summer_pkg::ph_read_wait;
            addr_q  <= haddr;
          end
          else
          begin
            phase_q <= setpoint_summer_pkg::ph_idle;
          end
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      in0_q <= `SPS_RST_INPUT;
      in1_q <= `SPS_RST_INPUT;
      in2_q <= `SPS_RST_INPUT;
    end
    else if (wr_ok)
    begin
      if (addr_q == `SPS_OFS_INPUT0)
      begin
        in0_q <= wdata_in;
      end
      else if (addr_q == `SPS_OFS_INPUT1)
      begin
        in1_q <= wdata_in;
      end
      else if (addr_q == `SPS_OFS_INPUT2)
      begin
        in2_q <= wdata_in;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ratio0_q <= `SPS_RST_COEF;
      ratio1_q <= `SPS_RST_COEF;
      div0_q   <= `SPS_RST_COEF;
      div1_q   <= `SPS_RST_COEF;
      limit_q  <= `SPS_RST_LIMIT;
      sign0_q  <= `SPS_RST_SIGN;
      sign1_q  <= `SPS_RST_SIGN;
    end
    else if (wr_ok)
    begin
      if (addr_q == `SPS_OFS_RATIO0)
      begin
        ratio0_q <= wdata_coef;
      end
      else if (addr_q == `SPS_OFS_RATIO1)
      begin
        ratio1_q <= wdata_coef;
      end
      else if (addr_q == `SPS_OFS_DIVIDER0)
      begin
        div0_q <= wdata_coef;
      end
      else if (addr_q == `SPS_OFS_DIVIDER1)
      begin
        div1_q <= wdata_coef;
      end
      else if (addr_q == `SPS_OFS_CTRL)
      begin
        sign0_q <= hwdata[`SPS_CTRL_SIGN0];
        sign1_q <= hwdata[`SPS_CTRL_SIGN1];
      end
      else if (addr_q == `SPS_OFS_LIMIT)
      begin
        limit_q <= wdata_lim;
      end
    end
  end

  // Channel math uses the registers as they stand, so a new setting shows one cycle later.
  assign ch0_d = scale(in0_q, ratio0_q, div0_q, sign0_q, limit_q);
  assign ch1_d = scale(in1_q, ratio1_q, div1_q, sign1_q, limit_q);
  assign sum_d = sat(32'(ch0_d) + 32'(ch1_d) + 32'(in2_q), 17'(limit_q));

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ch0_q <= 16'sh0000;
      ch1_q <= 16'sh0000;
      sum_q <= 16'sh0000;
    end
    else if (ce)
    begin
      ch0_q <= ch0_d;
      ch1_q <= ch1_d;
      sum_q <= sum_d;
    end
  end

  assign channel_zero_scaled_out = ch0_q;
  assign channel_one_scaled_out  = ch1_q;
  assign summed_setpoint_out     = sum_q;

  // Read data is taken in the wait cycle so a write just before is already visible.
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (addr_q == `SPS_OFS_INPUT0)
    begin
      rdata_d = 32'(in0_q);
    end
    else if (addr_q == `SPS_OFS_INPUT1)
    begin
      rdata_d = 32'(in1_q);
    end
    else if (addr_q == `SPS_OFS_INPUT2)
    begin
      rdata_d = 32'(in2_q);
    end
    else if (addr_q == `SPS_OFS_RATIO0)
    begin
      rdata_d = 32'(ratio0_q);
    end
    else if (addr_q == `SPS_OFS_RATIO1)
    begin
      rdata_d = 32'(ratio1_q);
    end
    else if (addr_q == `SPS_OFS_DIVIDER0)
    begin
      rdata_d = 32'(div0_q);
    end
    else if (addr_q == `SPS_OFS_DIVIDER1)
    begin
      rdata_d = 32'(div1_q);
    end
    else if (addr_q == `SPS_OFS_CTRL)
    begin
      rdata_d = {30'h0000_0000, sign1_q, sign0_q};
    end
    else if (addr_q == `SPS_OFS_LIMIT)
    begin
      rdata_d = 32'(limit_q);
    end
    else if (addr_q == `SPS_OFS_OUT0)
    begin
      rdata_d = 32'(ch0_q);
    end
    else if (addr_q == `SPS_OFS_OUT1)
    begin
      rdata_d = 32'(ch1_q);
    end
    else if (addr_q == `SPS_OFS_SUM)
    begin
      rdata_d = 32'(sum_q);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rdata_q <= 32'h0000_0000;
    end
    else if (ce && (phase_q == setpoint_summer_pkg::ph_read_wait))
    begin
      rdata_q <= rdata_d;
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_zero_div_zero: assert property (ce && (div0_q == 16'sh0000) |=> ch0_q == 16'sh0000)
    else $error("channel zero not zero with zero divider");

  a_zero_div_one: assert property (ce && (div1_q == 16'sh0000) |=> ch1_q == 16'sh0000)
    else $error("channel one not zero with zero divider");

  a_ch0_in_limit: assert property (ce |=> (ch0_q <= $past(limit_q)) && (ch0_q >= -$past(limit_q)))
    else $error("channel zero output exceeds limit");

  a_ch1_in_limit: assert property (ce |=> (ch1_q <= $past(limit_q)) && (ch1_q >= -$past(limit_q)))
    else $error("channel one output exceeds limit");

  a_sum_in_limit: assert property (ce |=> (sum_q <= $past(limit_q)) && (sum_q >= -$past(limit_q)))
    else $error("summed output exceeds limit");

  a_direct_input: assert property (ce && (div0_q == 16'sh0000) && (div1_q == 16'sh0000)
    && (in2_q <= limit_q) && (in2_q >= -limit_q) |=> sum_q == $past(in2_q))
    else $error("input two not passed straight to sum");

  a_unit_gain_pass: assert property (ce && sign0_q && (ratio0_q == div0_q) && (div0_q != 16'sh0000)
    && (in0_q <= limit_q) && (in0_q >= -limit_q) |=> ch0_q == $past(in0_q))
    else $error("unit ratio over divider does not pass input");

  a_negative_flip: assert property (ce && !sign1_q && (ratio1_q == div1_q) && (div1_q != 16'sh0000)
    && (in1_q <= limit_q) && (in1_q >= -limit_q) |=> ch1_q == -$past(in1_q))
    else $error("negative polarity does not negate channel one");

  a_coef_range: assert property ((ratio0_q <= 16'sh7530) && (ratio0_q >= -16'sh7530)
    && (div1_q <= 16'sh7530) && (div1_q >= -16'sh7530))
    else $error("coefficient outside span");

  a_input_range: assert property ((in0_q <= 16'sh7530) && (in0_q >= -16'sh7530))
    else $error("input zero outside span");

  a_limit_range: assert property ((limit_q >= 16'sh0000) && (limit_q <= 16'sh4E20))
    else $error("limit outside span");

  a_frozen_outputs: assert property (!ce |=> $stable(sum_q) && $stable(ch0_q))
    else $error("outputs change while clock enable is low");

  a_read_wait: assert property (accept && !hwrite |=> !hreadyout)
    else $error("read completes without wait state");

  c_sum_saturates: cover property (ce && (sum_d == limit_q) && (limit_q != 16'sh0000));
  c_zero_divider: cover property (ce && (div0_q == 16'sh0000) && (in0_q != 16'sh0000));
  c_read_done: cover property (phase_q == setpoint_summer_pkg::ph_read_done && hreadyout);
  c_negative_sum: cover property (ce && !sign0_q && (sum_d < 16'sh0000));

endmodule

//--- dv/setpoint_host_model.sv
// Bus master model standing in for the parameter store that feeds the setpoint summer.
module setpoint_host_model
(
  input  wire logic        hclk,
  input  wire logic        hreadyout,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [11:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    hsel   = 1'b0;
    haddr  = 12'h000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize  = 3'b010;
    hwdata = 32'h0000_0000;
  end

  // Call right after a rising edge. Ready and read data are taken at the rising edge itself,
  // before the slave's own update of that edge has landed.
  task automatic xfer(input logic [11:0] a, input logic w, input logic [2:0] sz,
                      input logic [31:0] d, output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= w;
    hsize  <= sz;
    do
    begin
      @(posedge hclk);
    end
    while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    // A read drives the bitwise inverse of whatever data is already on the bus.
    hwdata <= w ? d : ~hwdata;
    do
    begin
      @(posedge hclk);
    end
    while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
endmodule

//--- dv/setpoint_summer_tb.sv
// Self-checking testbench for the setpoint summer.
module setpoint_summer_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic               hclk      = 1'b0;
  logic               hresetn   = 1'b0;
  logic               ce        = 1'b1;
  logic               hsel;
  logic        [11:0] haddr;
  logic        [1:0]  htrans;
  logic               hwrite;
  logic        [2:0]  hsize;
  logic        [31:0] hwdata;
  logic               hreadyout;
  logic               hresp;
  logic        [31:0] hrdata;
  // Signed so that they widen the same way as the signed expected values do.
  logic signed [15:0] sum_o;
  logic signed [15:0] ch0_o;
  logic signed [15:0] ch1_o;
  int                 err_total = 0;
  int                 cmp_count = 0;
  int                 cyc       = 0;
  // Columns: in0 in1 in2 ratio0 ratio1 div0 div1 signs limit.
  int cs [0:6][0:8] = '{
    '{-1001, 2500, 333, 15000, -30000, 7001, 10000, 3, 20000},
    '{12000, -7000, -100, 10000, 20000, 0, 3000, 3, 20000},
    '{12000, -7000, -100, 10000, 20000, 3000, 0, 0, 20000},
    '{30000, 30000, 30000, 30000, 30000, 10000, 10000, 1, 20000},
    '{30000, -30000, -15000, 30000, 30000, 10000, -10000, 3, 5000},
    '{300, 200, -100, 10000, 10000, 10000, 10000, 3, 0},
    '{-30000, -30000, -30000, -30000, -30000, -30000, -30000, 2, 20000}};
  int rv [0:11] = '{0, 0, 0, 10000, 10000, 10000, 10000, 3, 10000, 0, 0, 0};

  always #25 hclk = ~hclk;

  setpoint_summer setpoint_summer_inst
  (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .summed_setpoint_out(sum_o), .channel_zero_scaled_out(ch0_o),
    .channel_one_scaled_out(ch1_o)
  );

  setpoint_host_model setpoint_host_model_inst
  (
    .hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (err_total == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  function automatic int sat(input int v, input int l);
    return (v > l) ? l : ((v < -l) ? -l : v);
  endfunction

  // Divide truncates toward zero; negation comes before the clamp.
  function automatic int chan(input int i, input int r, input int d, input bit pos,
                              input int l);
    int v;
    v = (d == 0) ? 0 : (i * r) / d;
    return sat(pos ? v : -v, l);
  endfunction

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    setpoint_host_model_inst.xfer(a, 1'b1, 3'b010, d, r);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    setpoint_host_model_inst.xfer(a, 1'b0, 3'b010, 32'h0000_0000, r);
    check(r, e);
  endtask

  task automatic t_reset();
    for (int k = 0; k < 12; k++)
      rd(12'(4 * k), 32'(rv[k]));
    rd(12'h030, 32'h0000_0000);
    check(sum_o, 16'h0000);
    check(hresp, 1'b0);
  endtask

  task automatic t_refuse();
    logic [31:0] r;
    wr(12'h024, 32'h0000_1234);
    rd(12'h024, 32'h0000_0000);
    setpoint_host_model_inst.xfer(12'h000, 1'b1, 3'b001, 32'h0000_0005, r);
    rd(12'h000, 32'h0000_0000);
    wr(12'h00C, 32'(-31000));
    rd(12'h00C, 32'(-30000));
    wr(12'h014, 32'(31000));
    rd(12'h014, 32'(30000));
    wr(12'h020, 32'(-5));
    rd(12'h020, 32'h0000_0000);
    wr(12'h020, 32'(25000));
    rd(12'h020, 32'(20000));
    wr(12'h008, 32'(40000));
    rd(12'h008, 32'(30000));
    wr(12'h008, 32'(-40000));
    rd(12'h008, 32'(-30000));
    check(sum_o, 16'(-20000));
  endtask

  task automatic t_stall();
    logic [31:0] r;
    ce <= 1'b0;
    fork
      setpoint_host_model_inst.xfer(12'h008, 1'b0, 3'b010, 32'h0000_0000, r);
      begin
        repeat (3) @(posedge hclk);
        check(hreadyout, 1'b0);
        ce <= 1'b1;
      end
    join
    check(r, 32'(-30000));
  endtask

  task automatic t_table();
    int e0;
    int e1;
    int es;
    for (int c = 0; c < 7; c++)
    begin
      for (int k = 0; k < 9; k++)
        wr(12'(4 * k), 32'(cs[c][k]));
      e0 = chan(cs[c][0], cs[c][3], cs[c][5], cs[c][7][0], cs[c][8]);
      e1 = chan(cs[c][1], cs[c][4], cs[c][6], cs[c][7][1], cs[c][8]);
      es = sat(e0 + e1 + cs[c][2], cs[c][8]);
      repeat (2) @(posedge hclk);
      check(ch0_o, 16'(e0));
      check(ch1_o, 16'(e1));
      check(sum_o, 16'(es));
      rd(12'h024, 32'(e0));
      rd(12'h028, 32'(e1));
      rd(12'h02C, 32'(es));
    end
  endtask

  // Both dividers at zero leave only the direct input in the sum; then channel one runs
  // alone at unit gain with negative polarity.
  task automatic t_direct();
    wr(12'h014, 32'h0000_0000);
    wr(12'h018, 32'h0000_0000);
    wr(12'h008, 32'(1234));
    repeat (2) @(posedge hclk);
    check(ch0_o, 16'h0000);
    check(ch1_o, 16'h0000);
    check(sum_o, 16'(1234));
    wr(12'h01C, 32'h0000_0001);
    wr(12'h010, 32'(5000));
    wr(12'h018, 32'(5000));
    wr(12'h004, 32'(700));
    repeat (2) @(posedge hclk);
    check(ch1_o, 16'(-700));
    check(sum_o, 16'(534));
    rd(12'h01C, 32'h0000_0001);
  endtask

  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      results();
    end
  end

  initial
  begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_refuse();
    t_stall();
    t_table();
    t_direct();
    results();
  end
endmodule
